// File: common/ppw_consts.vh
// Constants for the push-pull PWM output block: register offsets,
// field positions, mode codes and reset values.
// Assumes inclusion by bare name from the top-level design file only.
`ifndef PPW_CONSTS_VH
`define PPW_CONSTS_VH

// Register offsets (byte addresses, 8-bit registers)
`define PPW_AW 3
`define PPW_DW 8
`define PPW_OFF_CON 3'h0
`define PPW_OFF_CLK 3'h1
`define PPW_OFF_DBR 3'h2
`define PPW_OFF_DBF 3'h3
`define PPW_OFF_STR 3'h4
`define PPW_OFF_STAT 3'h5

// Control register fields
`define PPW_CON_EN 7
`define PPW_CON_LOAD 6
`define PPW_CON_DBR_EN 5
`define PPW_CON_DBF_EN 4
`define PPW_CON_MODE_HI 3
`define PPW_CON_MODE_LO 0

// Mode codes
`define PPW_MODE_SINGLE 4'h0
`define PPW_MODE_COMP 4'h1
`define PPW_MODE_PP 4'h2
`define PPW_MODE_PP_COMP 4'h3
`define PPW_MODE_PP4 4'h4
`define PPW_MODE_PP6 4'h5

// Clock select codes
`define PPW_CLK_SYS 2'h0
`define PPW_CLK_64M 2'h1
`define PPW_CLK_EXT 2'h2

// Reset values
`define PPW_RST_CON 8'h00
`define PPW_RST_CLK 2'h0
`define PPW_RST_DB 8'h00
`define PPW_RST_STR 6'h01

`endif

// File: rtl/ppw_deadband.v
// Dead-band timer: counts working-clock ticks after a start pulse.
// Assumes len is non-zero; a zero length is bypassed by the caller.
`timescale 1ns/1ps
`default_nettype none
module ppw_deadband #(
  parameter W = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Control
  input wire start,
  input wire [W-1:0] len,
  input wire tick,
  // Status
  output reg busy_q,
  output reg done_q
);
  reg [W-1:0] cnt_q;
  reg [W-1:0] len_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= {W{1'b0}};
      len_q <= {W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q <= {W{1'b0}};
        len_q <= len;
        busy_q <= 1'b1;
      end else if (busy_q && tick) begin
        if (cnt_q + 1'b1 >= len_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/ppw_period_flag.v
// Odd/even period flag for push-pull alternation.
// Assumes period_evt is a one-cycle pulse on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ppw_period_flag (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Control
  input wire enable,
  input wire period_evt,
  // Flag
  output reg odd_q
);
  always @(posedge sys_clk) begin
    if (srst) begin
      odd_q <= 1'b1;
    end else if (!enable) begin
      odd_q <= 1'b1;
    end else if (period_evt) begin
      odd_q <= ~odd_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/ppw_top.v
// Push-pull PWM output waveform logic with register port.
// Assumes synchronous one-cycle event pulses and tick inputs.
//
// Contract
// - Basic push-pull pulses on A in odd periods, B in even.
// - Basic push-pull drives only A and B, no dead band or steering.
// - Odd rise sets A, odd fall clears A; even periods use B.
// - Complementary push-pull: primaries on A,B; complements on E,F.
// - Odd rise: E inactive, rising dead band, then A active.
// - Odd fall: A inactive, falling dead band, then E active.
// - Even events do the same on B and F.
// - Four-output full bridge uses only A to D, no dead band.
// - Odd events drive bridge outs zero and two; even one and three.
// - In full-bridge modes A equals C and B equals D.
// - Six-output: primaries A to D, complements E,F, dead band.
// - Six-output odd rise: E off, dead band, A and C on.
// - Six-output even rise: F off, dead band, B and D on.
// - Enabling write with the load bit also set loads buffered steering and dead-band times.
// - Complementary single-phase value enables both dead bands.
// - Clock select one picks the 64 MHz tick source.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ppw_consts.vh"
module ppw_top #(
  parameter DBW = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Register port
  input wire [`PPW_AW-1:0] reg_addr,
  input wire [`PPW_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`PPW_DW-1:0] reg_rdata_q,
  // Events
  input wire period_evt,
  input wire rise_evt,
  input wire fall_evt,
  // Working clock ticks
  input wire tick_64m,
  input wire tick_ext,
  // PWM outputs
  output reg pwm_out_a_q,
  output reg pwm_out_b_q,
  output reg pwm_out_c_q,
  output reg pwm_out_d_q,
  output reg pwm_out_e_q,
  output reg pwm_out_f_q
);

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  function is_pp;
    input [3:0] m;
    begin
      is_pp = (m == `PPW_MODE_PP) || (m == `PPW_MODE_PP_COMP) ||
              (m == `PPW_MODE_PP4) || (m == `PPW_MODE_PP6);
    end
  endfunction

  function has_db;
    input [3:0] m;
    begin
      has_db = (m == `PPW_MODE_COMP) || (m == `PPW_MODE_PP_COMP) ||
               (m == `PPW_MODE_PP6);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg en_q;
  reg dbr_en_q;
  reg dbf_en_q;
  reg [3:0] mode_q;
  reg [1:0] clk_sel_q;
  reg [DBW-1:0] dbr_buf_q;
  reg [DBW-1:0] dbf_buf_q;
  reg [DBW-1:0] dbr_act_q;
  reg [DBW-1:0] dbf_act_q;
  reg [5:0] str_buf_q;
  reg [5:0] str_act_q;

  wire con_wr = reg_wr && (reg_addr == `PPW_OFF_CON);
  wire go_load = con_wr && reg_wdata[`PPW_CON_EN] &&
                 reg_wdata[`PPW_CON_LOAD];

  always @(posedge sys_clk) begin
    if (srst) begin
      en_q <= 1'b0;
      dbr_en_q <= 1'b0;
      dbf_en_q <= 1'b0;
      mode_q <= `PPW_MODE_SINGLE;
      clk_sel_q <= `PPW_RST_CLK;
      dbr_buf_q <= `PPW_RST_DB;
      dbf_buf_q <= `PPW_RST_DB;
      dbr_act_q <= `PPW_RST_DB;
      dbf_act_q <= `PPW_RST_DB;
      str_buf_q <= `PPW_RST_STR;
      str_act_q <= `PPW_RST_STR;
    end else begin
      if (con_wr) begin
        en_q <= reg_wdata[`PPW_CON_EN];
        dbr_en_q <= reg_wdata[`PPW_CON_DBR_EN];
        dbf_en_q <= reg_wdata[`PPW_CON_DBF_EN];
        mode_q <= reg_wdata[`PPW_CON_MODE_HI:`PPW_CON_MODE_LO];
      end
      if (go_load) begin
        dbr_act_q <= dbr_buf_q;
        dbf_act_q <= dbf_buf_q;
        str_act_q <= str_buf_q;
      end
      if (reg_wr && (reg_addr == `PPW_OFF_CLK)) begin
        clk_sel_q <= reg_wdata[1:0];
      end
      if (reg_wr && (reg_addr == `PPW_OFF_DBR)) begin
        dbr_buf_q <= reg_wdata[DBW-1:0];
      end
      if (reg_wr && (reg_addr == `PPW_OFF_DBF)) begin
        dbf_buf_q <= reg_wdata[DBW-1:0];
      end
      if (reg_wr && (reg_addr == `PPW_OFF_STR)) begin
        str_buf_q <= reg_wdata[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working clock tick
  reg tick;

  always @* begin
    case (clk_sel_q)
      `PPW_CLK_SYS: tick = 1'b1;
      `PPW_CLK_64M: tick = tick_64m;
      `PPW_CLK_EXT: tick = tick_ext;
      default: tick = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Period parity
  wire odd;

  ppw_period_flag u_flag (
    .sys_clk(sys_clk),
    .srst(srst),
    .enable(en_q),
    .period_evt(period_evt),
    .odd_q(odd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Event routing to output pairs (pair 0 odd/A/E, pair 1 even/B/F)
  reg [1:0] prim_q;
  reg [1:0] comp_q;
  reg [1:0] pend_p_q;
  reg [1:0] pend_c_q;
  reg [1:0] db_start;
  reg [DBW-1:0] db_len0;
  reg [DBW-1:0] db_len1;
  wire [1:0] db_busy;
  wire [1:0] db_done;

  wire sel = is_pp(mode_q) ? ~odd : 1'b0;
  wire db_ok = has_db(mode_q);
  wire use_dbr = db_ok && dbr_en_q && (dbr_act_q != {DBW{1'b0}});
  wire use_dbf = db_ok && dbf_en_q && (dbf_act_q != {DBW{1'b0}});
  wire ev_rise = en_q && rise_evt && !fall_evt;
  wire ev_fall = en_q && fall_evt;

  always @* begin
    db_start = 2'b00;
    db_len0 = dbr_act_q;
    db_len1 = dbr_act_q;
    if (ev_rise && use_dbr) begin
      db_start[sel] = 1'b1;
    end
    if (ev_fall && use_dbf) begin
      db_start[sel] = 1'b1;
      if (sel) begin
        db_len1 = dbf_act_q;
      end else begin
        db_len0 = dbf_act_q;
      end
    end
  end

  ppw_deadband #(
    .W(DBW)
  ) u_db0 (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(db_start[0]),
    .len(db_len0),
    .tick(tick),
    .busy_q(db_busy[0]),
    .done_q(db_done[0])
  );

  ppw_deadband #(
    .W(DBW)
  ) u_db1 (
    .sys_clk(sys_clk),
    .srst(srst),
    .start(db_start[1]),
    .len(db_len1),
    .tick(tick),
    .busy_q(db_busy[1]),
    .done_q(db_done[1])
  );

  ////////////////////////////////////////////////////////////////////////
  // Pair state
  integer i;

  always @(posedge sys_clk) begin
    if (srst) begin
      prim_q <= 2'b00;
      comp_q <= 2'b00;
      pend_p_q <= 2'b00;
      pend_c_q <= 2'b00;
    end else if (!en_q) begin
      prim_q <= 2'b00;
      comp_q <= 2'b00;
      pend_p_q <= 2'b00;
      pend_c_q <= 2'b00;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (db_done[i] && pend_p_q[i]) begin
          prim_q[i] <= 1'b1;
          pend_p_q[i] <= 1'b0;
        end
        if (db_done[i] && pend_c_q[i]) begin
          comp_q[i] <= 1'b1;
          pend_c_q[i] <= 1'b0;
        end
        if (ev_rise && (sel == i[0])) begin
          comp_q[i] <= 1'b0;
          pend_c_q[i] <= 1'b0;
          if (use_dbr) begin
            pend_p_q[i] <= 1'b1;
          end else begin
            prim_q[i] <= 1'b1;
          end
        end
        if (ev_fall && (sel == i[0])) begin
          prim_q[i] <= 1'b0;
          pend_p_q[i] <= 1'b0;
          if (use_dbf) begin
            pend_c_q[i] <= 1'b1;
          end else begin
            comp_q[i] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output mapping
  reg [5:0] out_d;

  always @* begin
    out_d = 6'h00;
    if (en_q) begin
      case (mode_q)
        `PPW_MODE_SINGLE: begin
          out_d = {6{prim_q[0]}} & str_act_q;
        end
        `PPW_MODE_COMP: begin
          out_d[0] = prim_q[0] & str_act_q[0];
          out_d[1] = comp_q[0] & str_act_q[1];
          out_d[2] = prim_q[0] & str_act_q[2];
          out_d[3] = comp_q[0] & str_act_q[3];
          out_d[4] = prim_q[0] & str_act_q[4];
        end
        `PPW_MODE_PP: begin
          out_d[0] = prim_q[0];
          out_d[1] = prim_q[1];
        end
        `PPW_MODE_PP_COMP: begin
          out_d[0] = prim_q[0];
          out_d[1] = prim_q[1];
          out_d[4] = comp_q[0];
          out_d[5] = comp_q[1];
        end
        `PPW_MODE_PP4: begin
          out_d[0] = prim_q[0];
          out_d[2] = prim_q[0];
          out_d[1] = prim_q[1];
          out_d[3] = prim_q[1];
        end
        `PPW_MODE_PP6: begin
          out_d[0] = prim_q[0];
          out_d[2] = prim_q[0];
          out_d[1] = prim_q[1];
          out_d[3] = prim_q[1];
          out_d[4] = comp_q[0];
          out_d[5] = comp_q[1];
        end
        default: out_d = 6'h00;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      pwm_out_a_q <= 1'b0;
      pwm_out_b_q <= 1'b0;
      pwm_out_c_q <= 1'b0;
      pwm_out_d_q <= 1'b0;
      pwm_out_e_q <= 1'b0;
      pwm_out_f_q <= 1'b0;
    end else begin
      pwm_out_a_q <= out_d[0];
      pwm_out_b_q <= out_d[1];
      pwm_out_c_q <= out_d[2];
      pwm_out_d_q <= out_d[3];
      pwm_out_e_q <= out_d[4];
      pwm_out_f_q <= out_d[5];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port
  reg [`PPW_DW-1:0] rd_d;

  always @* begin
    rd_d = 8'h00;
    case (reg_addr)
      `PPW_OFF_CON: begin
        rd_d = {en_q, 1'b0, dbr_en_q, dbf_en_q, mode_q};
      end
      `PPW_OFF_CLK: begin
        rd_d = {6'h00, clk_sel_q};
      end
      `PPW_OFF_DBR: begin
        rd_d = dbr_buf_q;
      end
      `PPW_OFF_DBF: begin
        rd_d = dbf_buf_q;
      end
      `PPW_OFF_STR: begin
        rd_d = {2'h0, str_buf_q};
      end
      `PPW_OFF_STAT: begin
        rd_d = {1'b0, odd, db_busy, comp_q, prim_q};
      end
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= reg_rd ? rd_d : 8'h00;
    end
  end

endmodule
`default_nettype wire

// File: sim/ppw_bridge_model.sv
// Bridge and secondary switch model: counts shorted legs.
// Assumes outputs ordered a..f in bit 0..5, active high.
`timescale 1ns/1ps
`default_nettype none
module ppw_bridge_model (
  // Clock
  input wire logic sys_clk,
  // Gate drives
  input wire logic [5:0] gate,
  // Shorted leg count
  output int shoot_cnt
);
  initial shoot_cnt = 0;
  // Primary with its complement, or both primaries
  always @(posedge sys_clk) begin
    if ((gate[0] && gate[4]) || (gate[1] && gate[5]) || (gate[0] && gate[1])) begin
      shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// File: sim/ppw_top_asserts.sv
// Checker for the push-pull PWM block.
// Assumes it is bound to every ppw_top.
`timescale 1ns/1ps
`default_nettype none
module ppw_top_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Events
  input wire logic period_evt,
  input wire logic rise_evt,
  input wire logic fall_evt,
  // Outputs
  input wire logic pwm_out_a_q,
  input wire logic pwm_out_b_q,
  input wire logic pwm_out_c_q,
  input wire logic pwm_out_d_q,
  input wire logic pwm_out_e_q,
  input wire logic pwm_out_f_q
);
  logic en_q;
  logic odd_q;
  logic [3:0] mode_q;
  wire [3:0] m = en_q ? mode_q : 4'hF;
  wire up = rise_evt && !fall_evt;
  wire nodb = m == 4'h2 || m == 4'h4;
  wire pp = m >= 4'h2 && m <= 4'h5;
  wire cpp = m == 4'h3 || m == 4'h5;
  always @(posedge sys_clk) begin
    if (srst) begin
      en_q <= 1'b0;
      mode_q <= 4'h0;
    end else if (reg_wr && reg_addr == 3'h0) begin
      en_q <= reg_wdata[7];
      mode_q <= reg_wdata[3:0];
    end
  end
  always @(posedge sys_clk) begin
    if (srst || !en_q) begin
      odd_q <= 1'b1;
    end else if (period_evt) begin
      odd_q <= !odd_q;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data not idle");
  odd_rise_a: assert property (
    nodb && up && odd_q |-> ##2 pwm_out_a_q) else $error("a late");
  even_rise_a: assert property (
    nodb && up && !odd_q |-> ##2 pwm_out_b_q) else $error("b late");
  odd_fall_a: assert property (
    pp && fall_evt && odd_q |-> ##2 !pwm_out_a_q) else $error("a held");
  comp_off_a: assert property (
    cpp && up && odd_q |-> ##2 !pwm_out_e_q) else $error("e held");
  pp2_pins_a: assert property (
    m == 4'h2 |-> !pwm_out_c_q && !pwm_out_d_q && !pwm_out_e_q
    && !pwm_out_f_q) else $error("extra pin in pp2");
  pp4_pins_a: assert property (
    m == 4'h4 |-> !pwm_out_e_q && !pwm_out_f_q) else $error("e or f in pp4");
  mirror_a: assert property (
    m == 4'h4 || m == 4'h5 |-> pwm_out_a_q == pwm_out_c_q
    && pwm_out_b_q == pwm_out_d_q) else $error("bridge pins differ");
  no_overlap_a: assert property (
    cpp |-> !(pwm_out_a_q && pwm_out_e_q) && !(pwm_out_b_q && pwm_out_f_q))
    else $error("pair overlap");
  cover property (nodb && up && !odd_q);
  cover property (cpp && fall_evt);
  cover property (m == 4'h5 && pwm_out_f_q);
endmodule
bind ppw_top ppw_top_asserts chk_i (
  .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .period_evt(period_evt),
  .rise_evt(rise_evt), .fall_evt(fall_evt),
  .pwm_out_a_q(pwm_out_a_q), .pwm_out_b_q(pwm_out_b_q),
  .pwm_out_c_q(pwm_out_c_q), .pwm_out_d_q(pwm_out_d_q),
  .pwm_out_e_q(pwm_out_e_q), .pwm_out_f_q(pwm_out_f_q)
);
`default_nettype wire

// File: sim/tb.sv
// Testbench for the push-pull PWM block.
// Assumes checker and bridge model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tick = 1'b0;
  logic tick_x = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  wire [7:0] rdata;
  wire [5:0] outs;
  int shoot;
  int num_errors = 0;
  int compares = 0;
  ppw_top #(.DBW(8)) uut (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata),
    .period_evt(ev[0]), .rise_evt(ev[1]), .fall_evt(ev[2]),
    .tick_64m(tick), .tick_ext(tick_x),
    .pwm_out_a_q(outs[0]), .pwm_out_b_q(outs[1]), .pwm_out_c_q(outs[2]),
    .pwm_out_d_q(outs[3]), .pwm_out_e_q(outs[4]), .pwm_out_f_q(outs[5])
  );
  ppw_bridge_model bridge (.sys_clk(sys_clk), .gate(outs), .shoot_cnt(shoot));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic waitc(input int n, input logic [5:0] e);
    repeat (n) @(posedge sys_clk);
    #1 chk({2'h0, outs}, {2'h0, e});
  endtask
  // Event bits: 0 period, 1 rise, 2 fall
  task automatic evc(input logic [2:0] v, input int n, input logic [5:0] e);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 3'h0;
    waitc(n, e);
  endtask
  task automatic off;
    wr(3'h0, 8'h00);
    waitc(2, 6'h00);
  endtask
  task automatic results;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    rdc(3'h0, 8'h00);
    rdc(3'h4, 8'h01);
    wr(3'h6, 8'hFF);
    rdc(3'h6, 8'h00);
    $display("regs done");
  endtask
  task automatic t_pp3;
    wr(3'h2, 8'h03);
    wr(3'h3, 8'h03);
    wr(3'h0, 8'hF3);
    evc(3'h2, 4, 6'h00);
    waitc(2, 6'h01);
    evc(3'h4, 4, 6'h00);
    waitc(2, 6'h10);
    evc(3'h1, 3, 6'h10);
    evc(3'h2, 4, 6'h10);
    waitc(2, 6'h12);
    evc(3'h4, 4, 6'h10);
    waitc(2, 6'h30);
    off();
    $display("pp3 done");
  endtask
  task automatic t_pp24(input logic [7:0] con, input logic [5:0] o, e);
    wr(3'h0, con);
    evc(3'h2, 3, o);
    evc(3'h4, 3, 6'h00);
    evc(3'h1, 3, 6'h00);
    evc(3'h2, 3, e);
    evc(3'h4, 3, 6'h00);
    evc(3'h1, 3, 6'h00);
    evc(3'h2, 3, o);
    off();
    $display("pp %h done", con);
  endtask
  task automatic t_pp6;
    wr(3'h2, 8'h05);
    wr(3'h0, 8'hB5);
    evc(3'h2, 4, 6'h00);
    waitc(2, 6'h05);
    evc(3'h4, 4, 6'h00);
    waitc(2, 6'h10);
    evc(3'h1, 3, 6'h10);
    evc(3'h2, 4, 6'h10);
    waitc(2, 6'h1A);
    evc(3'h4, 4, 6'h10);
    waitc(2, 6'h30);
    off();
    $display("pp6 done");
  endtask
  task automatic t_comp;
    wr(3'h4, 8'h03);
    wr(3'h0, 8'hF1);
    rdc(3'h0, 8'hB1);
    evc(3'h2, 6, 6'h00);
    waitc(2, 6'h01);
    evc(3'h4, 4, 6'h00);
    waitc(2, 6'h02);
    off();
    $display("comp done");
  endtask
  task automatic t_single;
    wr(3'h4, 8'h05);
    wr(3'h0, 8'hC0);
    evc(3'h2, 3, 6'h05);
    evc(3'h4, 3, 6'h00);
    rdc(3'h5, 8'h44);
    evc(3'h1, 3, 6'h00);
    rdc(3'h5, 8'h04);
    rdc(3'h2, 8'h05);
    off();
    $display("single done");
  endtask
  // Five tick pulses: bit 0 on tick, bit 1 on tick_x
  task automatic pulses(input logic [1:0] w);
    repeat (5) begin
      @(posedge sys_clk);
      tick <= w[0];
      tick_x <= w[1];
      @(posedge sys_clk);
      tick <= 1'b0;
      tick_x <= 1'b0;
    end
  endtask
  task automatic t_clk(input logic [1:0] cs);
    wr(3'h1, {6'h00, cs});
    rdc(3'h1, {6'h00, cs});
    wr(3'h0, 8'hF3);
    evc(3'h2, 12, 6'h00);
    pulses(~cs);
    waitc(3, 6'h00);
    pulses(cs);
    waitc(3, 6'h01);
    off();
    wr(3'h1, 8'h00);
    $display("clk %h done", cs);
  endtask
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_pp3();
    t_pp24(8'hF2, 6'h01, 6'h02);
    t_pp24(8'hF4, 6'h05, 6'h0A);
    t_pp6();
    t_comp();
    t_single();
    t_clk(2'h1);
    t_clk(2'h2);
    chk(shoot[7:0], 8'h00);
    results();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
